// >>> src/lpd_i2c_slave.sv
// Two-wire bus target giving a host write and read access to control registers.
// Assumes scl_clk is the bus clock from the master; sda pin resolved outside.
`timescale 1ns/100ps
module lpd_i2c_slave
   import lpd_pkg::*;
(
   input  wire logic                   clk_sys,
   input  wire logic                   rst_n,
   input  wire logic                   scl_clk,
   input  wire logic                   sda_i,
   output logic                        sda_o,
   output logic                        sda_oe,
   input  wire logic                   addr_sel,
   input  wire logic                   auto_inc_en,
   output logic                        bus_busy,
   output lpd_pkg::lpd_wr_s            reg_wr
);
   import lpd_pkg::*;

   function automatic logic [6:0] own_addr(input logic sel);
      own_addr = sel ? TGT_ADDR_HI : TGT_ADDR_LO;
   endfunction

   // Bus-clock domain: data captured at each clock rise
   logic link_smp_r;

   always_ff @(posedge scl_clk) begin
      link_smp_r <= sda_i;
   end

   // Synchronisers into clk_sys
   logic scl_s1, scl_s2, scl_s3, scl_s4;
   logic sda_s1, sda_s2, sda_s3;
   logic smp_s1, smp_s2;
   logic sel_s1, sel_s2;
   logic inc_s1, inc_s2;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         {scl_s1, scl_s2, scl_s3, scl_s4} <= 4'hF;
         {sda_s1, sda_s2, sda_s3}         <= 3'h7;
         {smp_s1, smp_s2}                 <= 2'h3;
         {sel_s1, sel_s2}                 <= 2'h0;
         {inc_s1, inc_s2}                 <= 2'h0;
      end else begin
         {scl_s1, scl_s2, scl_s3, scl_s4} <= {scl_clk, scl_s1, scl_s2, scl_s3};
         {sda_s1, sda_s2, sda_s3}         <= {sda_i, sda_s1, sda_s2};
         {smp_s1, smp_s2}                 <= {link_smp_r, smp_s1};
         {sel_s1, sel_s2}                 <= {addr_sel, sel_s1};
         {inc_s1, inc_s2}                 <= {auto_inc_en, inc_s1};
      end
   end

   // Rise event is late enough that the captured bit has crossed
   logic rise_ev, fall_ev, start_det, stop_det, bit_in;
   assign rise_ev   = scl_s3 & ~scl_s4;
   assign fall_ev   = ~scl_s3 & scl_s4;
   assign bit_in    = smp_s2;
   assign start_det = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
   assign stop_det  = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;

   // Protocol state
   lpd_state_e        state_r, state_nxt;
   logic [3:0]        cnt_r, cnt_nxt;
   logic [7:0]        shreg_r, shreg_nxt;
   logic [7:0]        tx_r, tx_nxt;
   logic [7:0]        ptr_r, ptr_nxt;
   logic              rw_r, rw_nxt;
   logic              oe_r, oe_nxt;
   logic              busy_r, busy_nxt;
   lpd_wr_s           wr_r, wr_nxt;
   logic [7:0]        rd_data;
   logic [7:0]        ptr_inc;

   assign ptr_inc = inc_s2 ? ptr_r + PTR_STEP : ptr_r;

   always_comb begin
      state_nxt  = state_r;
      cnt_nxt    = cnt_r;
      shreg_nxt  = shreg_r;
      tx_nxt     = tx_r;
      ptr_nxt    = ptr_r;
      rw_nxt     = rw_r;
      oe_nxt     = oe_r;
      busy_nxt   = busy_r;
      wr_nxt     = wr_r;
      wr_nxt.valid = 1'b0;
      if (start_det) begin
         state_nxt = ST_ADDR;
         cnt_nxt   = CNT_ZERO;
         oe_nxt    = 1'b0;
         busy_nxt  = 1'b1;
      end else if (stop_det) begin
         state_nxt = ST_IDLE;
         oe_nxt    = 1'b0;
         busy_nxt  = 1'b0;
      end else begin
         case (state_r)
            ST_ADDR, ST_REG, ST_WDATA: begin
               if (rise_ev && cnt_r < BYTE_BITS) begin
                  shreg_nxt = {shreg_r[6:0], bit_in};
                  cnt_nxt   = cnt_r + CNT_ONE;
               end
               if (fall_ev && cnt_r == BYTE_BITS) begin
                  cnt_nxt = CNT_ZERO;
                  oe_nxt  = 1'b1;
                  if (state_r == ST_ADDR) begin
                     if (shreg_r[7:1] == own_addr(sel_s2)) begin
                        rw_nxt    = shreg_r[0];
                        state_nxt = ST_AACK;
                     end else begin
                        oe_nxt    = 1'b0;
                        state_nxt = ST_IDLE;
                     end
                  end else if (state_r == ST_REG) begin
                     ptr_nxt   = shreg_r;
                     state_nxt = ST_RACK;
                  end else begin
                     state_nxt = ST_WACK;
                  end
               end
            end
            ST_AACK: begin
               if (fall_ev) begin
                  if (rw_r == DIR_READ) begin
                     oe_nxt    = ~rd_data[7];
                     tx_nxt    = {rd_data[6:0], 1'b0};
                     cnt_nxt   = CNT_ONE;
                     state_nxt = ST_RDATA;
                  end else begin
                     oe_nxt    = 1'b0;
                     state_nxt = ST_REG;
                  end
               end
            end
            ST_RACK: begin
               if (fall_ev) begin
                  oe_nxt    = 1'b0;
                  state_nxt = ST_WDATA;
               end
            end
            ST_WACK: begin
               if (rise_ev) begin
                  wr_nxt.valid = 1'b1;
                  wr_nxt.addr  = ptr_r;
                  wr_nxt.data  = shreg_r;
                  ptr_nxt      = ptr_inc;
               end
               if (fall_ev) begin
                  oe_nxt    = 1'b0;
                  state_nxt = ST_WDATA;
               end
            end
            ST_RDATA: begin
               if (fall_ev) begin
                  if (cnt_r == BYTE_BITS) begin
                     oe_nxt    = 1'b0;
                     cnt_nxt   = CNT_ZERO;
                     state_nxt = ST_MACK;
                  end else begin
                     oe_nxt  = ~tx_r[7];
                     tx_nxt  = {tx_r[6:0], 1'b0};
                     cnt_nxt = cnt_r + CNT_ONE;
                  end
               end
            end
            ST_MACK: begin
               if (rise_ev) begin
                  shreg_nxt = {shreg_r[6:0], bit_in};
                  if (bit_in == ACK_LEVEL) begin
                     ptr_nxt = ptr_inc;
                  end
               end
               if (fall_ev) begin
                  if (shreg_r[0] == ACK_LEVEL) begin
                     oe_nxt    = ~rd_data[7];
                     tx_nxt    = {rd_data[6:0], 1'b0};
                     cnt_nxt   = CNT_ONE;
                     state_nxt = ST_RDATA;
                  end else begin
                     state_nxt = ST_IDLE;
                  end
               end
            end
            ST_IDLE: begin
               oe_nxt = 1'b0;
            end
            default: begin
               state_nxt = ST_IDLE;
               oe_nxt    = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         cnt_r   <= CNT_ZERO;
         shreg_r <= BYTE_ZERO;
         tx_r    <= BYTE_ZERO;
         ptr_r   <= PTR_RESET;
         rw_r    <= 1'b0;
         oe_r    <= 1'b0;
         busy_r  <= 1'b0;
         wr_r    <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         shreg_r <= shreg_nxt;
         tx_r    <= tx_nxt;
         ptr_r   <= ptr_nxt;
         rw_r    <= rw_nxt;
         oe_r    <= oe_nxt;
         busy_r  <= busy_nxt;
         wr_r    <= wr_nxt;
      end
   end

   lpd_regmem u_regmem (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .wr      (wr_r),
      .rd_addr (ptr_r),
      .rd_data (rd_data)
   );

   // Open-drain: only ever pulls low, never makes start or stop itself
   assign sda_o    = 1'b0;
   assign sda_oe   = oe_r;
   assign bus_busy = busy_r;
   assign reg_wr   = wr_r;

   sequence s_wack_rise;
      state_r == ST_WACK && rise_ev && !start_det && !stop_det;
   endsequence

   sequence s_addr_miss;
      state_r == ST_ADDR && fall_ev && cnt_r == BYTE_BITS && !start_det && !stop_det
         && shreg_r[7:1] != own_addr(sel_s2);
   endsequence

   a_start_busy: assert property (@(posedge clk_sys) disable iff (!rst_n)
      start_det |=> busy_r && state_r == ST_ADDR && !oe_r)
      else $error("start not taken as session begin");

   a_stop_free: assert property (@(posedge clk_sys) disable iff (!rst_n)
      stop_det && !start_det |=> !busy_r && state_r == ST_IDLE)
      else $error("stop not taken as session end");

   a_commit_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_wack_rise |=> wr_r.valid && wr_r.data == $past(shreg_r) && wr_r.addr == $past(ptr_r))
      else $error("write not committed at acknowledge rise");

   a_commit_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_r.valid |-> $past(state_r) == ST_WACK && $past(rise_ev))
      else $error("write committed outside acknowledge rise");

   a_miss_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_addr_miss |=> state_r == ST_IDLE && !oe_r ##1 !oe_r)
      else $error("unmatched address was answered");

   a_ack_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_r == ST_AACK || state_r == ST_RACK || state_r == ST_WACK) |-> oe_r)
      else $error("received byte not acknowledged");

   a_master_ack: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_r == ST_MACK |-> !oe_r)
      else $error("data line held during master acknowledge");

   a_bit_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_r == ST_ADDR && rise_ev && cnt_r == BYTE_BITS - CNT_ONE && !start_det && !stop_det
      |=> cnt_r == BYTE_BITS && shreg_r[0] == $past(bit_in))
      else $error("eighth bit not shifted in");

   a_auto_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_wack_rise ##0 inc_s2 |=> ptr_r == $past(ptr_r) + PTR_STEP)
      else $error("register address did not advance");

   a_dir_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_r == ST_AACK && fall_ev && rw_r && !start_det && !stop_det |=> state_r == ST_RDATA)
      else $error("read direction not followed");

endmodule // lpd_i2c_slave

// >>> src/lpd_pkg.sv
// Shared constants and types for the two-wire register access target.
// Assumes one system clock domain plus the bus clock as a second domain.
package lpd_pkg;

   localparam int          ADDR_W      = 8;
   localparam int          DATA_W      = 8;
   localparam int          MEM_DEPTH   = 256;
   localparam logic [3:0]  BYTE_BITS   = 4'h8;
   localparam logic [3:0]  CNT_ZERO    = 4'h0;
   localparam logic [3:0]  CNT_ONE     = 4'h1;
   localparam logic [6:0]  TGT_ADDR_LO = 7'h54;
   localparam logic [6:0]  TGT_ADDR_HI = 7'h55;
   localparam logic        DIR_READ    = 1'b1;
   localparam logic        ACK_LEVEL   = 1'b0;
   localparam logic [7:0]  PTR_STEP    = 8'h01;
   localparam logic [7:0]  PTR_RESET   = 8'h00;
   localparam logic [7:0]  BYTE_ZERO   = 8'h00;

   typedef enum logic [8:0] {
      ST_IDLE  = 9'b0_0000_0001,
      ST_ADDR  = 9'b0_0000_0010,
      ST_AACK  = 9'b0_0000_0100,
      ST_REG   = 9'b0_0000_1000,
      ST_RACK  = 9'b0_0001_0000,
      ST_WDATA = 9'b0_0010_0000,
      ST_WACK  = 9'b0_0100_0000,
      ST_RDATA = 9'b0_1000_0000,
      ST_MACK  = 9'b1_0000_0000
   } lpd_state_e;

   typedef struct packed {
      logic                valid;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   data;
   } lpd_wr_s;

endpackage

// >>> src/lpd_regmem.sv
// Register image kept for read-back: one write port, registered read data.
// Assumes the write strobe and read address are on clk_sys.
`timescale 1ns/100ps
module lpd_regmem
   import lpd_pkg::*;
(
   input  wire logic                   clk_sys,
   input  wire logic                   rst_n,
   input  wire lpd_pkg::lpd_wr_s       wr,
   input  wire logic [lpd_pkg::ADDR_W-1:0] rd_addr,
   output logic      [lpd_pkg::DATA_W-1:0] rd_data
);
   import lpd_pkg::*;

   logic [DATA_W-1:0] mem [MEM_DEPTH];
   logic [DATA_W-1:0] rd_data_nxt;

   always_comb begin
      rd_data_nxt = mem[rd_addr];
   end

   always_ff @(posedge clk_sys) begin
      if (wr.valid) begin
         mem[wr.addr] <= wr.data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rd_data <= BYTE_ZERO;
      end else begin
         rd_data <= rd_data_nxt;
      end
   end
endmodule // lpd_regmem

// >>> test/lpd_i2c_master.sv
// Two-wire bus master model: start, stop and byte transfers with acknowledge.
// Assumes a pull-up on the data wire; the bench resolves the wire level.
`timescale 1ns/100ps
module lpd_i2c_master #(
   parameter int HALF = 6
) (
   output logic      scl_clk,
   output logic      sda_m,
   input  wire logic sda_in
);
   logic tck;

   // 12 ns time base, phase unrelated to the system clock
   initial begin
      tck = 1'b0;
      scl_clk = 1'b1;
      sda_m = 1'b1;
      #3.3;
      forever #6 tck = ~tck;
   end

   task automatic ticks(input int n);
      repeat (n) @(posedge tck);
   endtask

   // Only this side forms start and stop
   task automatic start();
      ticks(2);
      sda_m = 1'b1;
      ticks(HALF);
      scl_clk = 1'b1;
      ticks(HALF);
      sda_m = 1'b0;
      ticks(HALF);
      scl_clk = 1'b0;
   endtask

   // Clock stays high afterwards while the bus is free
   task automatic stop();
      ticks(2);
      sda_m = 1'b0;
      ticks(HALF);
      scl_clk = 1'b1;
      ticks(HALF);
      sda_m = 1'b1;
      ticks(2 * HALF);
   endtask

   // Data moves only while the clock is low
   task automatic send_bit(input logic b, output logic s);
      ticks(2);
      sda_m = b;
      ticks(HALF);
      scl_clk = 1'b1;
      ticks(HALF / 2);
      s = sda_in;
      ticks(HALF / 2);
      scl_clk = 1'b0;
   endtask

   // Eight bits MSB first, then the acknowledge clock
   task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                       output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         send_bit(tx[i], s);
         rx[i] = s;
      end
      send_bit(mack, ack);
   endtask
endmodule // lpd_i2c_master

// >>> test/lpd_i2c_slave_tb.sv
// Bench for the two-wire register target: writes, read-back, address match.
// Assumes lpd_i2c_master as bus master and a pull-up on the data wire.
`timescale 1ns/100ps
module lpd_i2c_slave_tb;
   import lpd_pkg::*;

   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        addr_sel = 1'b0;
   logic        auto_inc_en = 1'b0;
   logic        scl_clk;
   logic        sda_m;
   logic        sda_o;
   logic        sda_oe;
   logic        bus_busy;
   wire         sda_w;
   lpd_wr_s     reg_wr;
   lpd_wr_s     exp_q[$];
   logic [7:0]  mem [256];
   logic [31:0] rng = 32'h0000_6149;
   logic [7:0]  ra;
   logic [7:0]  rx;
   logic        a;
   int          err_count = 0;
   int          samples_checked = 0;

   always #4 clk_sys = ~clk_sys;

   // Open drain: the target can only pull low
   assign sda_w = sda_m & (sda_oe ? sda_o : 1'b1);

   lpd_i2c_slave u_lpd_i2c_slave (
      .clk_sys     (clk_sys),
      .rst_n       (rst_n),
      .scl_clk     (scl_clk),
      .sda_i       (sda_w),
      .sda_o       (sda_o),
      .sda_oe      (sda_oe),
      .addr_sel    (addr_sel),
      .auto_inc_en (auto_inc_en),
      .bus_busy    (bus_busy),
      .reg_wr      (reg_wr)
   );

   lpd_i2c_master u_lpd_i2c_master (
      .scl_clk (scl_clk),
      .sda_m   (sda_m),
      .sda_in  (sda_w)
   );

   function automatic logic [7:0] rnd8();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng[7:0];
   endfunction

   function automatic logic [6:0] dev(input logic alt);
      return (addr_sel ^ alt) ? TGT_ADDR_HI : TGT_ADDR_LO;
   endfunction

   task automatic chk_val(input string what, input logic [16:0] e, input logic [16:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic chk_bit(input string what, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %b seen %b", what, e, g);
      end
   endtask

   task automatic wr_byte(input logic [7:0] b, input logic e);
      u_lpd_i2c_master.xfer(b, 1'b1, rx, a);
      chk_bit("ack", e, a);
   endtask

   task automatic write_seq(input logic [7:0] r, input int n);
      logic [7:0] d;
      logic [7:0] wa;
      u_lpd_i2c_master.start();
      chk_bit("busy after start", 1'b1, bus_busy);
      wr_byte({dev(1'b0), 1'b0}, ACK_LEVEL);
      wr_byte(r, ACK_LEVEL);
      for (int i = 0; i < n; i++) begin
         d = rnd8();
         wa = auto_inc_en ? r + i[7:0] : r;
         mem[wa] = d;
         exp_q.push_back({1'b1, wa, d});
         wr_byte(d, ACK_LEVEL);
      end
      u_lpd_i2c_master.stop();
      chk_bit("busy after stop", 1'b0, bus_busy);
   endtask

   task automatic read_back(input logic [7:0] r, input int n);
      logic [7:0] ea;
      u_lpd_i2c_master.start();
      wr_byte({dev(1'b0), 1'b0}, ACK_LEVEL);
      wr_byte(r, ACK_LEVEL);
      u_lpd_i2c_master.start();
      wr_byte({dev(1'b0), DIR_READ}, ACK_LEVEL);
      for (int i = 0; i < n; i++) begin
         ea = auto_inc_en ? r + i[7:0] : r;
         u_lpd_i2c_master.xfer(8'hFF, (i == n - 1), rx, a);
         chk_val("read data", {9'h000, mem[ea]}, {9'h000, rx});
      end
      u_lpd_i2c_master.stop();
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Each write pulse takes the oldest note
   always @(posedge clk_sys) begin
      if (rst_n && reg_wr.valid === 1'b1) begin
         chk_bit("commit in ack high", 1'b1, scl_clk);
         chk_val("write", (exp_q.size() == 0) ? 17'h0_0000 : exp_q.pop_front(), reg_wr);
      end
   end

   initial begin
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk_bit("idle busy", 1'b0, bus_busy);
      for (int s = 0; s < 2; s++) begin
         @(posedge clk_sys);
         addr_sel <= s[0];
         auto_inc_en <= s[0];
         repeat (4) @(posedge clk_sys);
         ra = rnd8();
         write_seq(ra, 3);
         read_back(ra, 3);
         // Other address: no ack, no write
         u_lpd_i2c_master.start();
         wr_byte({dev(1'b1), 1'b0}, 1'b1);
         wr_byte(rnd8(), 1'b1);
         u_lpd_i2c_master.stop();
         // Start in mid-byte restarts address reception
         u_lpd_i2c_master.start();
         for (int i = 0; i < 4; i++) begin
            u_lpd_i2c_master.send_bit(i[0], a);
         end
         ra = rnd8();
         write_seq(ra, 1);
         read_back(ra, 1);
      end
      chk_val("pending writes", 17'h0_0000, 17'(exp_q.size()));
      wrap_up();
   end

   initial begin
      repeat (100000) @(posedge clk_sys);
      err_count++;
      wrap_up();
   end
endmodule // lpd_i2c_slave_tb
